// ==== design/mad_pkg.sv ====
package mad_pkg;
    // ------------------------------------------------------------
    // extended register port and indices
    // ------------------------------------------------------------
    localparam logic [15:0] MAD_INDEX_PORT = 16'h03de;
    localparam logic [15:0] MAD_DATA_PORT = 16'h03df;
    localparam logic [7:0] MAD_IDX_APERTURE = 8'h14;
    localparam logic [7:0] MAD_IDX_RESP_EN = 8'h15;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int MAD_DEC_EN_BIT = 0;
    localparam int MAD_APSEL_LSB = 2;
    localparam int MAD_GFX_EN_BIT = 6;
    localparam int MAD_MMIO_EN_BIT = 7;
    localparam logic [7:0] MAD_INDEX_RST = 8'h00;
    localparam logic [7:0] MAD_APERTURE_RST = 8'h00;
    localparam logic [7:0] MAD_RESP_EN_RST = 8'h00;
    localparam logic [7:0] MAD_APERTURE_WMASK = 8'h1d;
    localparam logic [7:0] MAD_RESP_EN_WMASK = 8'hc0;
    // ------------------------------------------------------------
    // aperture size codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MAD_AP_256K = 3'b000,
        MAD_AP_512K = 3'b001,
        MAD_AP_1M = 3'b010,
        MAD_AP_2M = 3'b011,
        MAD_AP_4M = 3'b100,
        MAD_AP_8M = 3'b101
    } mad_aperture_t;
endpackage : mad_pkg

// ==== design/mad_decode.sv ====
// Overview of operation
// - codes 000..011 claim 256K, 512K, 1M, 2M windows from offset 0.
// - code 100 claims 4M, 101 claims 8M, codes 11x claim nothing.
// - the size field has no effect while decode enable bit 0 is 0.
// - the response enable register is index 15h behind port 3DF, R/W.
// - bit 6 set lets the device answer graphics memory accesses.
// - bit 7 set lets the device answer memory-mapped I/O accesses.
// - the enable register resets to 00h, bits 5-0 reserved read 0.
module mad_decode
    import mad_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // host i/o port access
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_hit,
    // host memory access qualifiers
    input wire logic [22:0] mem_offset,
    input wire logic gfx_range,
    input wire logic mmio_range,
    // decode results
    output logic gfx_claim,
    output logic mmio_claim
);
    // ------------------------------------------------------------
    // index and register state
    // ------------------------------------------------------------
    logic [7:0] index;
    logic [7:0] aperture;
    logic [7:0] resp_en;
    logic [7:0] next_index;
    logic [7:0] next_aperture;
    logic [7:0] next_resp_en;
    logic data_sel;

    assign data_sel = io_addr == MAD_DATA_PORT;

    always_comb begin
        next_index = index;
        next_aperture = aperture;
        next_resp_en = resp_en;
        if (io_wr && io_addr == MAD_INDEX_PORT) begin
            next_index = io_wdata;
        end
        if (io_wr && data_sel && index == MAD_IDX_APERTURE) begin
            next_aperture = io_wdata & MAD_APERTURE_WMASK;
        end
        if (io_wr && data_sel && index == MAD_IDX_RESP_EN) begin
            // reserved low bits are not stored
            next_resp_en = io_wdata & MAD_RESP_EN_WMASK;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            index <= MAD_INDEX_RST;
            aperture <= MAD_APERTURE_RST;
            resp_en <= MAD_RESP_EN_RST;
        end else begin
            index <= next_index;
            aperture <= next_aperture;
            resp_en <= next_resp_en;
        end
    end

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    logic [7:0] next_rdata;
    logic next_hit;

    always_comb begin
        next_rdata = 8'h00;
        next_hit = 1'b0;
        if (io_rd && io_addr == MAD_INDEX_PORT) begin
            next_rdata = index;
            next_hit = 1'b1;
        end else if (io_rd && data_sel) begin
            unique case (index)
                MAD_IDX_APERTURE: begin
                    next_rdata = aperture;
                    next_hit = 1'b1;
                end
                MAD_IDX_RESP_EN: begin
                    next_rdata = resp_en;
                    next_hit = 1'b1;
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            io_rdata <= 8'h00;
            io_hit <= 1'b0;
        end else begin
            io_rdata <= next_rdata;
            io_hit <= next_hit;
        end
    end

    // ------------------------------------------------------------
    // aperture and space decode
    // ------------------------------------------------------------
    // window bound kept as a shift count so the compare stays narrow
    logic [4:0] ap_bits;
    logic ap_valid;
    logic in_window;
    logic [2:0] ap_code;

    assign ap_code = aperture[MAD_APSEL_LSB +: 3];

    always_comb begin
        ap_bits = 5'd18;
        ap_valid = 1'b1;
        unique case (ap_code)
            MAD_AP_256K: ap_bits = 5'd18;
            MAD_AP_512K: ap_bits = 5'd19;
            MAD_AP_1M: ap_bits = 5'd20;
            MAD_AP_2M: ap_bits = 5'd21;
            MAD_AP_4M: ap_bits = 5'd22;
            MAD_AP_8M: ap_bits = 5'd23;
            default: ap_valid = 1'b0;
        endcase
    end

    // bit 0 clear: field ignored, no window restriction
    assign in_window = !aperture[MAD_DEC_EN_BIT] ||
        (ap_valid && (mem_offset >> ap_bits) == 23'h000000);

    logic next_gfx;
    logic next_mmio;

    always_comb begin
        next_gfx = gfx_range && in_window && resp_en[MAD_GFX_EN_BIT];
        next_mmio = mmio_range && resp_en[MAD_MMIO_EN_BIT];
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            gfx_claim <= 1'b0;
            mmio_claim <= 1'b0;
        end else begin
            gfx_claim <= next_gfx;
            mmio_claim <= next_mmio;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_gfx_gate;
        @(posedge clock) disable iff (!rst_n)
        !resp_en[MAD_GFX_EN_BIT] |=> !gfx_claim;
    endproperty
    a_gfx_gate: assert property (p_gfx_gate) else $error("gfx claimed");

    property p_mmio_follow;
        @(posedge clock) disable iff (!rst_n)
        mmio_range |=> mmio_claim == $past(resp_en[MAD_MMIO_EN_BIT]);
    endproperty
    a_mmio_follow: assert property (p_mmio_follow) else $error("mmio bad");

    property p_reserved_zero;
        @(posedge clock) disable iff (!rst_n)
        resp_en[5:0] == 6'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("rsv");

    // no disable here: this one has to look through the reset itself
    property p_rst_clr;
        @(posedge clock) !rst_n |=> resp_en == MAD_RESP_EN_RST;
    endproperty
    a_rst_clr: assert property (p_rst_clr) else $error("rst");

    property p_miss_read;
        @(posedge clock) disable iff (!rst_n)
        (io_rd && data_sel && index != MAD_IDX_APERTURE &&
            index != MAD_IDX_RESP_EN) |=> !io_hit && io_rdata == 8'h00;
    endproperty
    a_miss_read: assert property (p_miss_read) else $error("miss");

    sequence s_write_en;
        io_wr && data_sel && index == MAD_IDX_RESP_EN;
    endsequence
    property p_write_read;
        @(posedge clock) disable iff (!rst_n)
        s_write_en ##1 (io_rd && data_sel && !io_wr) |=>
            io_rdata == ($past(io_wdata, 2) & MAD_RESP_EN_WMASK);
    endproperty
    a_write_read: assert property (p_write_read) else $error("rdback");

    property p_reserved_code;
        @(posedge clock) disable iff (!rst_n)
        (aperture[MAD_DEC_EN_BIT] && ap_code[2:1] == 2'b11) |=> !gfx_claim;
    endproperty
    a_reserved_code: assert property (p_reserved_code) else $error("11x");

    property p_window_256k;
        @(posedge clock) disable iff (!rst_n)
        (aperture[MAD_DEC_EN_BIT] && ap_code == 3'b000 &&
            mem_offset[22:18] != 5'h00) |=> !gfx_claim;
    endproperty
    a_window_256k: assert property (p_window_256k) else $error("256k");

    property p_ignore_field;
        @(posedge clock) disable iff (!rst_n)
        (!aperture[MAD_DEC_EN_BIT] && gfx_range && resp_en[MAD_GFX_EN_BIT])
            |=> gfx_claim;
    endproperty
    a_ignore_field: assert property (p_ignore_field) else $error("ign");

    property p_window_8m;
        @(posedge clock) disable iff (!rst_n)
        (aperture[MAD_DEC_EN_BIT] && ap_code == 3'b101 && gfx_range &&
            resp_en[MAD_GFX_EN_BIT]) |=> gfx_claim;
    endproperty
    a_window_8m: assert property (p_window_8m) else $error("8m");
endmodule : mad_decode

// ==== test/mad_host.sv ====
module mad_host (
    // clock
    input wire logic clock,
    // host i/o port
    output logic io_wr,
    output logic io_rd,
    output logic [15:0] io_addr,
    output logic [7:0] io_wdata,
    // memory access qualifiers
    output logic [22:0] mem_offset,
    output logic gfx_range,
    output logic mmio_range
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {io_wr, io_rd, io_addr, io_wdata} = '0;
        {mem_offset, gfx_range, mmio_range} = '0;
    end
    // released lines flip, so a stale value never passes as held
    task automatic io_cycle(input logic rd, input logic [15:0] a,
                            input logic [7:0] d);
        @(negedge clock);
        io_rd = rd;
        io_wr = ~rd;
        io_addr = a;
        io_wdata = d;
        @(negedge clock);
        {io_rd, io_wr} = 2'b00;
        io_addr = ~a;
        io_wdata = ~d;
    endtask : io_cycle
    // write then read the same port with no idle cycle between
    task automatic io_wr_rd(input logic [15:0] a, input logic [7:0] d);
        @(negedge clock);
        io_wr = 1'b1;
        io_addr = a;
        io_wdata = d;
        @(negedge clock);
        {io_rd, io_wr} = 2'b10;
        io_wdata = ~d;
        @(negedge clock);
        {io_rd, io_wr} = 2'b00;
        io_addr = ~a;
    endtask : io_wr_rd
    task automatic mem_access(input logic [22:0] o, input logic g,
                              input logic m);
        @(negedge clock);
        mem_offset = o;
        gfx_range = g;
        mmio_range = m;
        @(negedge clock);
    endtask : mem_access
endmodule : mad_host

// ==== test/test_memory_aperture_decode.sv ====
module test_memory_aperture_decode
    import mad_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, rst_n, io_wr, io_rd, gfx_range, mmio_range;
    logic io_hit, gfx_claim, mmio_claim;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata, en, ap, v;
    logic [22:0] mem_offset, o;
    logic [23:0] sz;
    logic g, m, ge;
    int error_cnt = 0;
    int comparisons = 0;

    mad_decode mad_decode_inst (.clock(clock), .rst_n(rst_n),
        .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
        .mem_offset(mem_offset), .gfx_range(gfx_range),
        .mmio_range(mmio_range), .gfx_claim(gfx_claim),
        .mmio_claim(mmio_claim));
    mad_host mad_host_inst (.clock(clock), .io_wr(io_wr), .io_rd(io_rd),
        .io_addr(io_addr), .io_wdata(io_wdata), .mem_offset(mem_offset),
        .gfx_range(gfx_range), .mmio_range(mmio_range));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic end_sim();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp_byte

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_byte({7'h00, got}, {7'h00, exp});
    endtask : cmp_bit

    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
        mad_host_inst.io_cycle(1'b0, MAD_INDEX_PORT, idx);
        mad_host_inst.io_cycle(1'b0, MAD_DATA_PORT, d);
    endtask : reg_wr

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp,
                          input logic hit);
        mad_host_inst.io_cycle(1'b0, MAD_INDEX_PORT, idx);
        mad_host_inst.io_cycle(1'b1, MAD_DATA_PORT, 8'h00);
        cmp_byte(io_rdata, exp);
        cmp_bit(io_hit, hit);
    endtask : rd_chk

    // window from offset 0; 11x claims nothing, bit 0 clear claims all
    function automatic logic exp_gfx(logic [7:0] e, logic [7:0] a,
                                     logic [22:0] off);
        if (!e[6]) return 1'b0;
        if (!a[0]) return 1'b1;
        if (a[4:3] == 2'b11) return 1'b0;
        return {1'b0, off} < (24'h040000 << a[4:2]);
    endfunction : exp_gfx

    initial begin
        rst_n = 1'b0;
        void'($urandom(3));
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        rd_chk(MAD_IDX_RESP_EN, 8'h00, 1'b1);
        rd_chk(8'h20, 8'h00, 1'b0);
        repeat (8) begin
            v = 8'($urandom);
            reg_wr(MAD_IDX_RESP_EN, v);
            rd_chk(MAD_IDX_RESP_EN, v & 8'hc0, 1'b1);
            mad_host_inst.io_cycle(1'b1, MAD_INDEX_PORT, 8'h00);
            cmp_byte(io_rdata, MAD_IDX_RESP_EN);
            v = 8'($urandom);
            mad_host_inst.io_wr_rd(MAD_DATA_PORT, v);
            cmp_byte(io_rdata, v & 8'hc0);
        end
        // mid-run reset must drop both enables and the index again
        reg_wr(MAD_IDX_RESP_EN, 8'hc0);
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        mad_host_inst.io_cycle(1'b1, MAD_INDEX_PORT, 8'h00);
        cmp_byte(io_rdata, 8'h00);
        rd_chk(MAD_IDX_RESP_EN, 8'h00, 1'b1);
        for (int e = 0; e < 4; e++) begin
            for (int a = 0; a < 16; a++) begin
                en = 8'(e << 6);
                ap = {3'b000, a[3:1], 1'b0, a[0]};
                sz = 24'h040000 << a[3:1];
                reg_wr(MAD_IDX_RESP_EN, en);
                reg_wr(MAD_IDX_APERTURE, ap);
                rd_chk(MAD_IDX_APERTURE, ap, 1'b1);
                for (int k = 0; k < 3; k++) begin
                    o = (k == 2) ? 23'($urandom) : 23'(sz - 24'(k ^ 1));
                    g = 1'($urandom);
                    // both spaces enabled: keep the ranges apart
                    m = 1'($urandom) & ~(g & en[6] & en[7]);
                    mad_host_inst.mem_access(o, g, m);
                    ge = gfx_range & exp_gfx(en, ap, o);
                    cmp_bit(gfx_claim, ge);
                    cmp_bit(mmio_claim, mmio_range & en[7]);
                end
            end
        end
        end_sim();
    end

    // whole test needs about 1300 cycles, the sweep about 1150; allow a wide margin
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end
endmodule : test_memory_aperture_decode
